// [pir_pkg.sv]
// package for the peripheral input remap block: map, fields, keys, states
// Notes on behaviour
// - lock set: remap register writes ignored
// - lock clear: remap register writes accepted
// - config write needs prior unlock sequence
// - config unimplemented bits read zero, ignored
// - select 0: irq one selector high byte
// - select 1: irq three high, two low
// - select 2: timer one clock, high byte
// - selects 3-5: capture high, timer low
// - reset clears selectors and lock bit
`default_nettype none
package pir_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int SEL_W = 8;
	localparam int NUM_INSEL = 6;
	localparam int NUM_FIELDS = 10;
	localparam int NUM_PINS = 64;
	// byte addresses on the register bus
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_INSEL0 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_INSEL_LAST = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_UNLOCK = 8'h1c;
	// remap_config layout
	localparam int LOCK_BIT = 11;
	localparam logic [REG_W-1:0] CONFIG_RESET = 16'h0000;
	localparam logic [REG_W-1:0] INSEL_RESET = 16'h0000;
	// implemented bits of each input_select register
	localparam logic [REG_W-1:0] INSEL_MASK [NUM_INSEL] =
		'{16'hff00, 16'hffff, 16'hff00, 16'hffff, 16'hffff, 16'hffff};
	// per field: owning register and lowest bit
	// order: irq1, irq2, irq3, timer1 clock, cap1, ccp tmr1, cap2, ccp tmr2, cap3, ccp tmr3
	localparam int FIELD_REG [NUM_FIELDS] = '{0, 1, 1, 2, 3, 3, 4, 4, 5, 5};
	localparam int FIELD_LSB [NUM_FIELDS] = '{8, 0, 8, 8, 8, 0, 8, 0, 8, 0};
	// unlock keys, written back to back to the unlock register
	localparam logic [REG_W-1:0] UNLOCK_KEY_A = 16'h5a5a;
	localparam logic [REG_W-1:0] UNLOCK_KEY_B = 16'ha5a5;
	typedef enum {KEY_IDLE, KEY_HALF, KEY_ARMED} pir_key_state_type;
endpackage
`default_nettype wire

// [pir_unlock_gate.sv]
// unlock sequence tracker guarding writes to remap_config
`timescale 1ns/10ps
`default_nettype none
module pir_unlock_gate
	import pir_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// completed bus writes
	input wire logic busWrite,
	input wire logic keyWrite,
	input wire logic [pir_pkg::REG_W-1:0] keyData,
	// one write may follow
	output logic armed
);
	pir_key_state_type keyState;
	pir_key_state_type next_keyState;

	always_comb
	begin
		next_keyState = keyState;
		case (keyState)
			KEY_IDLE:
				if (keyWrite && keyData == UNLOCK_KEY_A)
					next_keyState = KEY_HALF;
			KEY_HALF:
				if (keyWrite && keyData == UNLOCK_KEY_B)
					next_keyState = KEY_ARMED;
				else if (busWrite)
					next_keyState = KEY_IDLE;
			KEY_ARMED:
				// any write spends the permission, used or not
				if (busWrite)
					next_keyState = KEY_IDLE;
			default:
				next_keyState = KEY_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			keyState <= KEY_IDLE;
		else
			keyState <= next_keyState;
	end

	assign armed = (keyState == KEY_ARMED);

	a_armed_spent: assert property (@(posedge clk) disable iff (!resetn)
		armed && busWrite |=> !armed)
		else $error("unlock permission survived a write");
endmodule
`default_nettype wire

// [pir_pin_select.sv]
// one selector-driven synchronous pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module pir_pin_select #(
	parameter int NUM_PINS = 64,
	parameter int SEL_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// candidate pins and selector
	input wire logic [NUM_PINS-1:0] pins,
	input wire logic [SEL_W-1:0] sel,
	// routed peripheral input
	output logic routed
);
	logic inRange;

	// value zero and values past the last pin choose no pin
	assign inRange = (sel != '0) && (32'(sel) <= NUM_PINS);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			routed <= 1'b0;
		else
			routed <= inRange ? pins[32'(sel) - 1] : 1'b0;
	end

	a_route_follows: assert property (@(posedge clk) disable iff (!resetn)
		inRange ##1 $stable(sel) |-> routed == $past(pins[32'(sel) - 1]))
		else $error("routed input does not follow selected pin");
	a_route_idle: assert property (@(posedge clk) disable iff (!resetn)
		!inRange |=> !routed)
		else $error("routed input active with no pin selected");
endmodule
`default_nettype wire

// [pir_remap_top.sv]
// peripheral input remap: register file on the bus and the input routing
`timescale 1ns/10ps
`default_nettype none
module pir_remap_top
	import pir_pkg::*;
#(
	parameter int NUM_PINS = pir_pkg::NUM_PINS
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pir_pkg::ADDR_W-1:0] paddr,
	input wire logic [pir_pkg::DATA_W-1:0] pwdata,
	output logic [pir_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// remappable pins
	input wire logic [NUM_PINS-1:0] remappablePin,
	// routed peripheral inputs
	output logic externalIrqOne,
	output logic externalIrqTwo,
	output logic externalIrqThree,
	output logic timerOneExtClock,
	output logic captureUnit1In,
	output logic ccpTimer1ClockIn,
	output logic captureUnit2In,
	output logic ccpTimer2ClockIn,
	output logic captureUnit3In,
	output logic ccpTimer3ClockIn,
	// lock state for the rest of the chip
	output logic remapLockOut
);
	// register state
	logic remapLock;
	logic [REG_W-1:0] inputSelect [NUM_INSEL];
	// bus decode
	logic access;
	logic done;
	logic writeDone;
	logic configHit;
	logic inselHit;
	logic unlockHit;
	logic addrHit;
	logic [2:0] inselIdx;
	logic [REG_W-1:0] readValue;
	logic unlockArmed;
	logic [SEL_W-1:0] fieldSel [NUM_FIELDS];
	logic [NUM_FIELDS-1:0] routed;

	// bus phase decode; one wait state keeps read data from a flop
	assign access = psel && penable;
	assign done = access && pready;
	assign writeDone = done && pwrite;

	// address decode, word aligned only
	assign configHit = (paddr == OFS_CONFIG);
	assign unlockHit = (paddr == OFS_UNLOCK);
	assign inselHit = (paddr[1:0] == 2'b00) && (paddr >= OFS_INSEL0)
		&& (paddr <= OFS_INSEL_LAST);
	assign inselIdx = 3'(paddr[ADDR_W-1:2] - 6'(OFS_INSEL0 >> 2));
	assign addrHit = configHit || unlockHit || inselHit;

	// read mux; unimplemented bits come back as zero
	always_comb
	begin
		readValue = '0;
		if (configHit)
		begin
			// only the lock bit reads back
			readValue[LOCK_BIT] = remapLock;
		end
		else if (unlockHit)
			readValue = {15'h0000, unlockArmed};
		else if (inselHit)
			readValue = inputSelect[inselIdx] & INSEL_MASK[inselIdx];
	end

	// bus answer: ready in the second access cycle, data and error with it
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= access && !pready;
			if (access && !pready)
			begin
				prdata <= pwrite ? '0 : {16'h0000, readValue};
				pslverr <= !addrHit;
			end
			else
			begin
				prdata <= '0;
				pslverr <= 1'b0;
			end
		end
	end

	// unlock sequence tracking
	pir_unlock_gate unlockGate (
		.clk(clk),
		.resetn(resetn),
		.busWrite(writeDone),
		.keyWrite(writeDone && unlockHit),
		.keyData(pwdata[REG_W-1:0]),
		.armed(unlockArmed)
	);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			remapLock <= CONFIG_RESET[LOCK_BIT];
		else if (writeDone && configHit && unlockArmed)
			remapLock <= pwdata[LOCK_BIT];
	end

	// lock state exported from its own flop
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			remapLockOut <= 1'b0;
		else if (writeDone && configHit && unlockArmed)
			remapLockOut <= pwdata[LOCK_BIT];
	end

	// selector registers, one per input_select word
	for (genvar i = 0; i < NUM_INSEL; i++)
	begin : gSel
		always_ff @(posedge clk or negedge resetn)
		begin
			if (!resetn)
				inputSelect[i] <= INSEL_RESET;
			else if (writeDone && inselHit && inselIdx == 3'(i) && !remapLock)
				inputSelect[i] <= pwdata[REG_W-1:0] & INSEL_MASK[i];
		end
	end

	// field extraction and routing muxes
	// field placement
	for (genvar f = 0; f < NUM_FIELDS; f++)
	begin : gField
		assign fieldSel[f] = inputSelect[FIELD_REG[f]][FIELD_LSB[f] +: SEL_W];
		pir_pin_select #(
			.NUM_PINS(NUM_PINS),
			.SEL_W(SEL_W)
		) pinSelect (
			.clk(clk),
			.resetn(resetn),
			.pins(remappablePin),
			.sel(fieldSel[f]),
			.routed(routed[f])
		);
	end

	// routed inputs, each from its mux flop
	assign externalIrqOne = routed[0];
	assign externalIrqTwo = routed[1];
	assign externalIrqThree = routed[2];
	assign timerOneExtClock = routed[3];
	assign captureUnit1In = routed[4];
	assign ccpTimer1ClockIn = routed[5];
	assign captureUnit2In = routed[6];
	assign ccpTimer2ClockIn = routed[7];
	assign captureUnit3In = routed[8];
	assign ccpTimer3ClockIn = routed[9];

	// checks on the register file
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_insel_write;
		writeDone && inselHit;
	endsequence

	sequence s_config_write;
		writeDone && configHit;
	endsequence

	// key pair at the tightest idle-separated spacing, nothing written between
	sequence s_key_pair;
		writeDone && unlockHit && pwdata[REG_W-1:0] == UNLOCK_KEY_A
		##1 (!writeDone)[*3]
		##1 writeDone && unlockHit && pwdata[REG_W-1:0] == UNLOCK_KEY_B;
	endsequence

	a_lock_blocks_write: assert property (
		s_insel_write and remapLock |=> inputSelect[$past(inselIdx)]
			== $past(inputSelect[inselIdx]))
		else $error("selector changed while locked");

	a_unlock_stores_data: assert property (
		s_insel_write and !remapLock |=> inputSelect[$past(inselIdx)]
			== ($past(pwdata[REG_W-1:0]) & INSEL_MASK[$past(inselIdx)]))
		else $error("unlocked selector write not stored");

	a_config_needs_key: assert property (
		s_config_write and !unlockArmed |=> $stable(remapLock))
		else $error("config changed without unlock");
	a_config_after_key: assert property (
		s_key_pair ##1 (!writeDone)[*3] ##1 s_config_write
			|=> remapLock == $past(pwdata[LOCK_BIT]))
		else $error("config write after unlock not taken");
	a_key_arms: assert property (
		s_key_pair |=> unlockArmed)
		else $error("key pair did not arm the config write");
	a_armed_write_lands: assert property (
		s_config_write and unlockArmed |=> remapLock == $past(pwdata[LOCK_BIT]))
		else $error("armed config write not stored");

	a_config_reserved: assert property (
		access && !pready && !pwrite && configHit |=> pready
			&& prdata[REG_W-1:LOCK_BIT+1] == '0 && prdata[LOCK_BIT-1:0] == '0)
		else $error("config reserved bits not zero");

	a_low_bytes_zero: assert property (
		inputSelect[0][7:0] == 8'h00 && inputSelect[2][7:0] == 8'h00)
		else $error("unimplemented selector byte set");

	a_two_fields_set: assert property (
		s_insel_write and !remapLock and inselIdx == 3'd1 |=>
			fieldSel[2] == $past(pwdata[15:8]) && fieldSel[1] == $past(pwdata[7:0]))
		else $error("select 1 fields mismatch");

	a_capture_route: assert property (
		fieldSel[4] == 8'h01 ##1 fieldSel[4] == 8'h01
			|-> captureUnit1In == $past(remappablePin[0]))
		else $error("capture unit 1 not routed from pin");

	a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
		!resetn |-> !remapLock && inputSelect[3] == '0 && !pready)
		else $error("state not cleared in reset");

	// one wait state on every access
	a_bus_one_wait: assert property (
		psel && !penable ##1 access |-> !pready ##1 pready)
		else $error("bus answer not after one wait");

	// single-cycle answer pulse; a request held past ready is answered again two cycles later
	a_ready_one_cycle: assert property (
		pready |=> !pready)
		else $error("ready held past one cycle");

	// read data and error only beside ready
	a_idle_data_zero: assert property (
		!pready |-> prdata == '0 && !pslverr)
		else $error("bus answer outside ready cycle");

	// upper half of every answer is zero
	a_upper_half_zero: assert property (
		pready |-> prdata[DATA_W-1:REG_W] == '0)
		else $error("upper read data bits set");

	// unmapped addresses flag an error and return zero
	a_unmapped_error: assert property (
		access && !pready && !addrHit |=> pready && pslverr && prdata == '0)
		else $error("unmapped access not flagged");
	a_mapped_no_error: assert property (
		access && !pready && addrHit |=> pready && !pslverr)
		else $error("mapped access flagged as error");

	// reads return the stored selector word
	a_insel_readback: assert property (
		access && !pready && !pwrite && inselHit |=> prdata
			== {16'h0000, $past(inputSelect[inselIdx] & INSEL_MASK[inselIdx])})
		else $error("selector read back wrong");

	// unlock register shows the armed state
	a_unlock_readback: assert property (
		access && !pready && !pwrite && unlockHit |=> prdata == {31'h00000000, $past(unlockArmed)})
		else $error("armed state read back wrong");

	// lock moves only on an armed config write
	a_lock_stable: assert property (
		!(writeDone && configHit && unlockArmed) |=> $stable(remapLock))
		else $error("lock changed without armed write");

	// exported lock tracks the register bit
	a_lock_copy: assert property (
		remapLockOut == remapLock)
		else $error("exported lock differs");

	// selectors 1 and 5 change only on a bus write
	a_select_hold: assert property (
		!(writeDone && inselHit) |=> $stable(inputSelect[1]) && $stable(inputSelect[5]))
		else $error("selector changed with no write");
endmodule
`default_nettype wire

// [peripheral_input_remap_bench.sv]
// self-checking bench for the peripheral input remap block
`timescale 1ns/10ps
`default_nettype none
module peripheral_input_remap_bench;
	import pir_pkg::*;
	// bus and pin drive, all driven from the bench
	logic clk = 1'b0;
	// starts high so the first assertion is a real falling edge
	logic resetn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [NUM_PINS-1:0] remappablePin = '0;
	// design answers
	wire logic [DATA_W-1:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic [NUM_FIELDS-1:0] routed;
	wire logic remapLockOut;
	// expected read answers, oldest first
	logic [DATA_W:0] readNote [$];
	logic [REG_W-1:0] shadow [NUM_INSEL];
	logic [31:0] seed = 32'd45226;
	int failCount = 0;
	int testsRun = 0;

	pir_remap_top i_pir_remap_top (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.remappablePin(remappablePin), .externalIrqOne(routed[0]), .externalIrqTwo(routed[1]),
		.externalIrqThree(routed[2]), .timerOneExtClock(routed[3]), .captureUnit1In(routed[4]),
		.ccpTimer1ClockIn(routed[5]), .captureUnit2In(routed[6]), .ccpTimer2ClockIn(routed[7]),
		.captureUnit3In(routed[8]), .ccpTimer3ClockIn(routed[9]), .remapLockOut(remapLockOut)
	);

	// free-running 50 MHz clock
	initial
	begin
		forever #10 clk = ~clk;
	end

	// xorshift source, fixed start for repeatable runs
	function automatic logic [31:0] nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic report(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
		failCount++;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	endtask

	// read answer: {pslverr, prdata}
	task automatic checkRead(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
		testsRun++;
		if (got !== exp)
			report(got, exp);
	endtask

	// routed inputs plus lock copy
	task automatic checkRoute(input logic [NUM_FIELDS:0] got, input logic [NUM_FIELDS:0] exp);
		testsRun++;
		if (got !== exp)
			report({22'h0, got}, {22'h0, exp});
	endtask

	task automatic testDone();
		$display("comparisons %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one apb transfer; held until pready is sampled, then one idle cycle
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
		input logic [DATA_W:0] exp);
		int n;
		n = 0;
		if (!wr)
			readNote.push_back(exp);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			report('0, 33'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		apb(1'b1, a, d, '0);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		apb(1'b0, a, '0, {17'h0, d});
	endtask

	task automatic unlock();
		wr(OFS_UNLOCK, UNLOCK_KEY_A);
		wr(OFS_UNLOCK, UNLOCK_KEY_B);
	endtask

	function automatic logic [ADDR_W-1:0] selAddr(input int i);
		return OFS_INSEL0 + 8'(4 * i);
	endfunction

	// read results: each answer takes the oldest note
	always @(posedge clk)
	begin
		if (pready === 1'b1 && pwrite === 1'b0)
		begin
			if (readNote.size() == 0)
				report({pslverr, prdata}, '0);
			else
				checkRead({pslverr, prdata}, readNote.pop_front());
		end
	end

	// watchdog, well beyond the expected run length
	initial
	begin
		#(20 * 30000);
		report('0, 33'h1);
		testDone();
	end

	initial
	begin
		logic [31:0] r;
		logic [SEL_W-1:0] s [NUM_FIELDS];
		logic [REG_W-1:0] val [NUM_INSEL];
		logic [NUM_FIELDS-1:0] exp;
		resetn <= 1'b0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(OFS_CONFIG, CONFIG_RESET);
		for (int i = 0; i < NUM_INSEL; i++)
			rd(selAddr(i), INSEL_RESET);
		apb(1'b0, 8'h20, '0, {1'b1, 32'h0});
		$display("test reset values done");
		// unlocked writes land, unimplemented bytes read zero
		for (int i = 0; i < NUM_INSEL; i++)
		begin
			r = nextRand();
			shadow[i] = r[15:0] & INSEL_MASK[i];
			wr(selAddr(i), r[15:0]);
			rd(selAddr(i), shadow[i]);
		end
		$display("test unlocked writes done");
		// config write needs the unlock keys in a row
		wr(OFS_CONFIG, 16'hffff);
		rd(OFS_CONFIG, 16'h0000);
		wr(OFS_UNLOCK, UNLOCK_KEY_A);
		wr(selAddr(0), shadow[0]);
		wr(OFS_UNLOCK, UNLOCK_KEY_B);
		wr(OFS_CONFIG, 16'hffff);
		rd(OFS_CONFIG, 16'h0000);
		unlock();
		rd(OFS_UNLOCK, 16'h0001);
		wr(OFS_CONFIG, 16'hffff);
		rd(OFS_CONFIG, 16'h0800);
		checkRoute({remapLockOut, routed}, {1'b1, 10'h000});
		for (int i = 0; i < NUM_INSEL; i++)
		begin
			wr(selAddr(i), ~shadow[i]);
			rd(selAddr(i), shadow[i]);
		end
		unlock();
		wr(OFS_CONFIG, 16'hf7ff);
		rd(OFS_CONFIG, 16'h0000);
		$display("test lock done");
		// each selector routes pin n-1, zero and out of range give 0
		for (int p = 0; p < 6; p++)
		begin
			for (int i = 0; i < NUM_INSEL; i++)
				val[i] = '0;
			for (int f = 0; f < NUM_FIELDS; f++)
			begin
				s[f] = SEL_W'(nextRand() % 66);
				// selector 1 (pin 0) on capture unit 1 once, then last pin and one past it
				if (p == 0 && f == 4)
					s[f] = 8'h01;
				if (p == 1)
					s[f] = (f < 5) ? 8'h40 : 8'h41;
				val[FIELD_REG[f]][FIELD_LSB[f] +: SEL_W] = s[f];
			end
			for (int i = 0; i < NUM_INSEL; i++)
				wr(selAddr(i), val[i]);
			for (int k = 0; k < 4; k++)
			begin
				remappablePin <= {nextRand(), nextRand()};
				repeat (3) @(posedge clk);
				for (int f = 0; f < NUM_FIELDS; f++)
					exp[f] = (s[f] >= 1 && s[f] <= NUM_PINS) ? remappablePin[s[f] - 1] : 1'b0;
				checkRoute({remapLockOut, routed}, {1'b0, exp});
			end
		end
		$display("test routing done");
		// a second reset in mid-run clears all again
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(OFS_CONFIG, CONFIG_RESET);
		for (int i = 0; i < NUM_INSEL; i++)
			rd(selAddr(i), INSEL_RESET);
		$display("test second reset done");
		testDone();
	end
endmodule
`default_nettype wire
